/* rtl/mwpm_channel.sv */
// What this block does
// - long-cycle mode when modulation enable is set and length is 9..11
// - cycle length N comes from the cycle-length select field
// - output goes high when low N counter bits equal the compare value
// - output goes low when the counter overflows out of bit N
// - each overflow sets the overflow flag and reloads compare from auto-reload
// - overflow recurs every 512, 1024 or 2048 counter clocks
// - with match-flag and compare enable set, each nonzero compare match sets the capture/compare flag
// - compare byte locations reach auto-reload when select is 1, else compare
// - writing the low compare byte clears compare enable
// - writing the high compare byte sets compare enable
// - compare enable cleared holds the output low, giving zero duty
// - high fraction is (2^N minus compare) over 2^N for nonzero compare; compare zero gives zero
`timescale 1ns/1ps
`include "mwpm_regs.svh"

module mwpm_channel
    import mwpm_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int CMP_W = 11
)
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [5:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [5:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic CHANNEL_OUTPUT,
    output logic IRQ
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [CNT_W-1:0] count_r;
    logic [CMP_W-1:0] compare_r;
    logic [CMP_W-1:0] reload_r;
    logic [1:0] cl_sel_r;
    logic reload_access_select_r;
    logic ecom_r;
    logic pwm_sel_r;
    logic mat_en_r;
    logic [1:0] mask_r;
    logic out_r;
    logic irq_r;
    logic cycle_overflow_flag;
    logic ccf;
    mwpm_wr_t wr_state_r;
    logic aw_got_r;
    logic w_got_r;
    logic [5:0] aw_addr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    logic wr_fire;
    logic wr_lo;
    logic wr_hi;
    logic wr_known;
    logic [CMP_W-1:0] lo_mask;
    logic [CMP_W-1:0] n_mask;
    logic [CMP_W-1:0] cnt_low;
    logic long_mode;
    logic ovf_pulse;
    logic match_pulse;
    logic [CMP_W-1:0] wr_lo_val;
    logic [CMP_W-1:0] wr_hi_val;

    // both halves held, response slot free: commit the write
    assign wr_fire = aw_got_r && w_got_r && (wr_state_r == MWPM_WR_IDLE);
    assign wr_lo = wr_fire && (aw_addr_r == `MWPM_ADDR_CMPLO) && wstrb_r[0];
    assign wr_hi = wr_fire && (aw_addr_r == `MWPM_ADDR_CMPHI) && wstrb_r[0];
    assign wr_known = (aw_addr_r == `MWPM_ADDR_MODCTL) || (aw_addr_r == `MWPM_ADDR_CHMODE)
        || (aw_addr_r == `MWPM_ADDR_CMPLO) || (aw_addr_r == `MWPM_ADDR_CMPHI)
        || (aw_addr_r == `MWPM_ADDR_STATUS) || (aw_addr_r == `MWPM_ADDR_MASK)
        || (aw_addr_r == `MWPM_ADDR_COUNT);
    assign lo_mask = CMP_W'(8'hff);

    // ------------------------------------------------------------
    // cycle length and events
    // ------------------------------------------------------------
    // n-bit mask from the length field; 8-bit code falls back to 8 bits
    always_comb
    begin
        unique case (mwpm_len_t'(cl_sel_r))
            MWPM_LEN8: n_mask = CMP_W'(12'h0ff);
            MWPM_LEN9: n_mask = CMP_W'(12'h1ff);
            MWPM_LEN10: n_mask = CMP_W'(12'h3ff);
            MWPM_LEN11: n_mask = CMP_W'(12'h7ff);
        endcase
    end

    assign cnt_low = count_r[CMP_W-1:0] & n_mask;
    // long-cycle mode needs modulation select and a length above 8 bits
    assign long_mode = pwm_sel_r && (cl_sel_r != `MWPM_CL_8);
    // low n bits all ones: next tick carries out of bit n, every 2^n clocks
    assign ovf_pulse = long_mode && (cnt_low == n_mask);
    // match with enable clear never fires, so output stays low
    assign match_pulse = long_mode && ecom_r && !ovf_pulse
        && (((count_r[CMP_W-1:0] + CMP_W'(1)) & n_mask) == (compare_r & n_mask));

    // free-running shared counter
    always_ff @(posedge CLK)
    begin
        if (SRST)
            count_r <= '0;
        else
            count_r <= count_r + CNT_W'(1);
    end

    // output: set on match, clear on overflow; high share is (2^n - cmp)/2^n, zero for cmp 0
    always_ff @(posedge CLK)
    begin
        if (SRST)
            out_r <= 1'b0;
        else if (!long_mode || !ecom_r || ovf_pulse)
            out_r <= 1'b0;
        else if (match_pulse)
            out_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // compare, auto-reload and mode registers
    // ------------------------------------------------------------
    assign wr_lo_val = CMP_W'(wdata_r[7:0]);
    assign wr_hi_val = CMP_W'({wdata_r[7:0], 8'h00});

    // software writes duty right-justified across both bytes
    always_ff @(posedge CLK)
    begin
        if (SRST)
            reload_r <= '0;
        else if (wr_lo && reload_access_select_r)
            reload_r <= (reload_r & ~lo_mask) | wr_lo_val;
        else if (wr_hi && reload_access_select_r)
            reload_r <= (reload_r & lo_mask) | wr_hi_val;
    end

    // overflow reload beats a same-cycle software write to the compare value
    always_ff @(posedge CLK)
    begin
        if (SRST)
            compare_r <= '0;
        else if (ovf_pulse)
            compare_r <= reload_r;
        else if (wr_lo && !reload_access_select_r)
            compare_r <= (compare_r & ~lo_mask) | wr_lo_val;
        else if (wr_hi && !reload_access_select_r)
            compare_r <= (compare_r & lo_mask) | wr_hi_val;
    end

    // byte writes steer compare enable in either mapping
    always_ff @(posedge CLK)
    begin
        if (SRST)
            ecom_r <= 1'b0;
        else if (wr_lo)
            ecom_r <= 1'b0;
        else if (wr_hi)
            ecom_r <= 1'b1;
        else if (wr_fire && aw_addr_r == `MWPM_ADDR_CHMODE && wstrb_r[0])
            ecom_r <= wdata_r[`MWPM_CM_ECOM_BIT];
    end

    // mode, control and mask registers
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            pwm_sel_r <= 1'b0;
            mat_en_r <= 1'b0;
            cl_sel_r <= `MWPM_CL_8;
            reload_access_select_r <= 1'b0;
            mask_r <= '0;
        end
        else if (wr_fire && wstrb_r[0])
        begin
            if (aw_addr_r == `MWPM_ADDR_CHMODE)
            begin
                pwm_sel_r <= wdata_r[`MWPM_CM_PWM_BIT];
                mat_en_r <= wdata_r[`MWPM_CM_MAT_BIT];
            end
            if (aw_addr_r == `MWPM_ADDR_MODCTL)
            begin
                cl_sel_r <= wdata_r[`MWPM_MC_CYCLE_LENGTH_SELECT_LSB +: 2];
                reload_access_select_r <= wdata_r[`MWPM_MC_RELOAD_ACCESS_SELECT_BIT];
            end
            if (aw_addr_r == `MWPM_ADDR_MASK)
                mask_r <= wdata_r[1:0];
        end
    end

    // ------------------------------------------------------------
    // sticky flags, write-one-to-clear; hardware never clears them
    // ------------------------------------------------------------
    logic wr_status;
    assign wr_status = wr_fire && (aw_addr_r == `MWPM_ADDR_STATUS) && wstrb_r[0];

    mwpm_edge_flag u_cycle_overflow_flag
    (
        .clk(CLK),
        .srst(SRST),
        .set_pulse(ovf_pulse),
        .clr_pulse(wr_status && wdata_r[`MWPM_ST_CYCLE_OVERFLOW_FLAG_BIT]),
        .flag(cycle_overflow_flag)
    );

    mwpm_edge_flag u_ccf
    (
        .clk(CLK),
        .srst(SRST),
        .set_pulse(match_pulse && mat_en_r),
        .clr_pulse(wr_status && wdata_r[`MWPM_ST_CCF_BIT]),
        .flag(ccf)
    );

    // level interrupt from unmasked flags, registered
    always_ff @(posedge CLK)
    begin
        if (SRST)
            irq_r <= 1'b0;
        else
            irq_r <= |({ccf, cycle_overflow_flag} & mask_r);
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    // address and data captured in either order; response after both
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_got_r <= 1'b1;
                aw_addr_r <= {S_AXI_AWADDR[5:2], 2'b00};
            end
            else if (wr_fire)
                aw_got_r <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_got_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
            end
            else if (wr_fire)
                w_got_r <= 1'b0;
        end
    end

    // response slot
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            wr_state_r <= MWPM_WR_IDLE;
            bvalid_r <= 1'b0;
            bresp_r <= `MWPM_RESP_OKAY;
        end
        else
        begin
            unique case (wr_state_r)
                MWPM_WR_IDLE:
                    if (wr_fire)
                    begin
                        wr_state_r <= MWPM_WR_RESP;
                        bvalid_r <= 1'b1;
                        bresp_r <= wr_known ? `MWPM_RESP_OKAY : `MWPM_RESP_SLVERR;
                    end
                MWPM_WR_RESP:
                    if (S_AXI_BREADY)
                    begin
                        wr_state_r <= MWPM_WR_IDLE;
                        bvalid_r <= 1'b0;
                    end
            endcase
        end
    end

    // ready flops: single-cycle pulses, low while a half is held
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_got_r && !S_AXI_AWREADY && S_AXI_AWVALID;
            S_AXI_WREADY <= !w_got_r && !S_AXI_WREADY && S_AXI_WVALID;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic [31:0] rd_word;
    logic rd_ok;
    logic [CMP_W-1:0] rd_cmp;
    assign rd_cmp = reload_access_select_r ? reload_r : compare_r;

    always_comb
    begin
        rd_word = '0;
        rd_ok = 1'b1;
        unique case ({S_AXI_ARADDR[5:2], 2'b00})
            `MWPM_ADDR_MODCTL:
            begin
                rd_word[`MWPM_MC_CYCLE_LENGTH_SELECT_LSB +: 2] = cl_sel_r;
                rd_word[`MWPM_MC_RELOAD_ACCESS_SELECT_BIT] = reload_access_select_r;
            end
            `MWPM_ADDR_CHMODE:
            begin
                rd_word[`MWPM_CM_PWM_BIT] = pwm_sel_r;
                rd_word[`MWPM_CM_MAT_BIT] = mat_en_r;
                rd_word[`MWPM_CM_ECOM_BIT] = ecom_r;
            end
            `MWPM_ADDR_CMPLO: rd_word[7:0] = rd_cmp[7:0];
            `MWPM_ADDR_CMPHI: rd_word[CMP_W-9:0] = rd_cmp[CMP_W-1:8];
            `MWPM_ADDR_STATUS: rd_word[1:0] = {ccf, cycle_overflow_flag};
            `MWPM_ADDR_MASK: rd_word[1:0] = mask_r;
            `MWPM_ADDR_COUNT: rd_word[CNT_W-1:0] = count_r;
            default: rd_ok = 1'b0;
        endcase
    end

    // one read at a time; arready pulses with the data load
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            S_AXI_ARREADY <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `MWPM_RESP_OKAY;
        end
        else
        begin
            S_AXI_ARREADY <= 1'b0;
            if (rvalid_r && S_AXI_RREADY)
                rvalid_r <= 1'b0;
            else if (!rvalid_r && !S_AXI_ARREADY && S_AXI_ARVALID)
            begin
                S_AXI_ARREADY <= 1'b1;
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= rd_ok ? `MWPM_RESP_OKAY : `MWPM_RESP_SLVERR;
            end
        end
    end

    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;
    assign CHANNEL_OUTPUT = out_r;
    assign IRQ = irq_r;

endmodule : mwpm_channel

/* rtl/mwpm_regs.svh */
`ifndef MWPM_REGS_SVH
`define MWPM_REGS_SVH

// register byte addresses
`define MWPM_ADDR_MODCTL 6'h00
`define MWPM_ADDR_CHMODE 6'h04
`define MWPM_ADDR_CMPLO 6'h08
`define MWPM_ADDR_CMPHI 6'h0c
`define MWPM_ADDR_STATUS 6'h10
`define MWPM_ADDR_MASK 6'h14
`define MWPM_ADDR_COUNT 6'h18

// modulation_control_reg fields
`define MWPM_MC_CYCLE_LENGTH_SELECT_LSB 0
`define MWPM_MC_RELOAD_ACCESS_SELECT_BIT 7

// channel_mode_reg fields
`define MWPM_CM_PWM_BIT 1
`define MWPM_CM_MAT_BIT 3
`define MWPM_CM_ECOM_BIT 6

// status / mask fields
`define MWPM_ST_CYCLE_OVERFLOW_FLAG_BIT 0
`define MWPM_ST_CCF_BIT 1

// cycle length select codes
`define MWPM_CL_8 2'h0
`define MWPM_CL_9 2'h1
`define MWPM_CL_10 2'h2
`define MWPM_CL_11 2'h3

`define MWPM_RESP_OKAY 2'h0
`define MWPM_RESP_SLVERR 2'h2

`endif

/* rtl/mwpm_pkg.sv */
package mwpm_pkg;

    // cycle length, bits per modulation period
    typedef enum logic [1:0]
    {
        MWPM_LEN8 = 2'h0,
        MWPM_LEN9 = 2'h1,
        MWPM_LEN10 = 2'h2,
        MWPM_LEN11 = 2'h3
    } mwpm_len_t;

    // axi-lite write slave states, gray along idle -> resp
    typedef enum logic [1:0]
    {
        MWPM_WR_IDLE = 2'h0,
        MWPM_WR_RESP = 2'h1
    } mwpm_wr_t;

endpackage : mwpm_pkg

/* rtl/mwpm_edge_flag.sv */
`timescale 1ns/1ps

// sticky flag: hardware set wins over a software clear in the same cycle
module mwpm_edge_flag
(
    input wire logic clk,
    input wire logic srst,
    input wire logic set_pulse,
    input wire logic clr_pulse,
    output logic flag
);

    always_ff @(posedge clk)
    begin
        if (srst)
            flag <= 1'b0;
        else if (set_pulse)
            flag <= 1'b1;
        else if (clr_pulse)
            flag <= 1'b0;
    end

endmodule : mwpm_edge_flag

/* testbench/mwpm_channel_asserts.sv */
`timescale 1ns/1ps

// ----------
// port checks
// ----------
module mwpm_channel_asserts
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CHANNEL_OUTPUT,
    input wire logic IRQ
);
    logic [10:0] ph_r;
    logic [11:0] hi_r;

    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);

    // mirror of the free-running counter, places each wrap edge
    always_ff @(posedge CLK)
        ph_r <= SRST ? 11'h000 : ph_r + 11'h001;

    // length of the current high stretch
    always_ff @(posedge CLK)
        hi_r <= (SRST || !CHANNEL_OUTPUT) ? 12'h000 : hi_r + 12'h001;

    // a write may force the pin low anywhere, so those edges are excused
    property p_fall_at_wrap;
        $fell(CHANNEL_OUTPUT) && !S_AXI_BVALID && !$past(S_AXI_BVALID) |-> ph_r[8:0] == 9'h000;
    endproperty
    a_fall_at_wrap: assert property (p_fall_at_wrap) else $error("fall off a wrap");

    property p_high_bound;
        hi_r <= 12'h7ff;
    endproperty
    a_high_bound: assert property (p_high_bound) else $error("high too long");

    property p_irq_sticky;
        $fell(IRQ) |-> $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2);
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped alone");

    property p_b_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer moved");

    property p_r_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer moved");

    property p_aw_answer;
        $rose(S_AXI_AWVALID) |=> S_AXI_AWREADY;
    endproperty
    a_aw_answer: assert property (p_aw_answer) else $error("address not taken");

    property p_ar_answer;
        $rose(S_AXI_ARVALID) |=> S_AXI_ARREADY && S_AXI_RVALID;
    endproperty
    a_ar_answer: assert property (p_ar_answer) else $error("read late");

    property p_b_after;
        // ready pulses one cycle, the commit follows a cycle later, then bvalid shows
        $rose(S_AXI_BVALID) |-> $past(S_AXI_AWREADY, 2) || $past(S_AXI_WREADY, 2);
    endproperty
    a_b_after: assert property (p_b_after) else $error("write answer early");

    cover property ($fell(CHANNEL_OUTPUT));
    cover property ($fell(IRQ));
    cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule : mwpm_channel_asserts

bind mwpm_channel mwpm_channel_asserts u_chk
(
    .CLK(CLK), .SRST(SRST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .CHANNEL_OUTPUT(CHANNEL_OUTPUT), .IRQ(IRQ)
);

/* testbench/mwpm_channel_bench.sv */
`timescale 1ns/1ps
`include "mwpm_regs.svh"

module mwpm_channel_bench
    import mwpm_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, chout, irq, last;
    logic [1:0] bresp, rresp, rs, wr_resp;
    logic [31:0] rdata, rd;
    int error_cnt = 0;
    int samples_checked = 0;
    int c;
    int cmps[4] = '{32'h0, 32'h180, 32'h001, 32'h7ff};

    // 25 MHz
    always #20 clk = ~clk;

    mwpm_channel u_dut
    (
        .CLK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .CHANNEL_OUTPUT(chout), .IRQ(irq)
    );

    // ----------
    // bus and check tasks
    // ----------
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // a used-up wait counts as a mismatch and closes the run
    task automatic lim(input int n);
        if (n >= 5000)
        begin
            error_cnt++;
            results();
        end
    endtask : lim

    task automatic axw(input logic [5:0] a, input logic [31:0] d);
        int n;
        logic ga, gw;
        n = 0;
        ga = 1'b0;
        gw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // each half is released at the edge that takes it
        do
        begin
            @(posedge clk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            ga |= awready;
            gw |= wready;
        end
        while (!(ga && gw) && n < 5000);
        // late bready lets the answer stand a cycle
        while (!bvalid && n < 5000)
        begin
            @(posedge clk);
            n++;
        end
        bready <= 1'b1;
        @(posedge clk);
        wr_resp = bresp;
        bready <= 1'b0;
        lim(n);
    endtask : axw

    task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!arready && n < 5000);
        arvalid <= 1'b0;
        while (!rvalid && n < 5000)
        begin
            @(posedge clk);
            n++;
        end
        rready <= 1'b1;
        @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        lim(n);
    endtask : axr

    task automatic rc(input logic [5:0] a, input logic [31:0] e);
        axr(a, rd, rs);
        chk(rd, e);
    endtask : rc

    // counts high samples of the pin
    task automatic cnt(input int len, output int k);
        k = 0;
        repeat (len)
        begin
            @(posedge clk);
            last = chout;
            // an unknown pin level must never pass as a low sample
            k += (chout === 1'b1) ? 1 : ((chout === 1'b0) ? 0 : 100000);
        end
    endtask : cnt

    // one full period measured from a wrap edge
    task automatic meas(input int n, input int e);
        int w;
        logic p;
        w = 0;
        last = chout;
        do
        begin
            @(posedge clk);
            p = last;
            last = chout;
            w++;
        end
        while (!(p && !last) && w < 5000);
        lim(w);
        cnt((1 << n) - 1, c);
        chk(c, e);
        p = last;
        cnt(1, w);
        chk(32'({p, last}), 32'h2);
    endtask : meas

    task automatic endt(input int t);
        $display("test %0d done", t);
    endtask : endt

    // ----------
    // sequence
    // ----------
    initial
    begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 6; i++)
            rc(6'(i * 4), 32'h0);
        axr(6'h1c, rd, rs);
        chk({30'h0, rs}, 32'h2);
        axw(6'h1c, 32'h0);
        chk({30'h0, wr_resp}, 32'h2);
        // back-to-back reads sample the free-running counter three clocks apart
        axr(`MWPM_ADDR_COUNT, rd, rs);
        c = int'(rd);
        rc(`MWPM_ADDR_COUNT, 32'(c + 3));
        endt(1);
        axw(`MWPM_ADDR_MASK, 32'h3);
        for (int i = 1; i < 4; i++)
        begin
            axw(`MWPM_ADDR_MODCTL, 32'h80 | i);
            axw(`MWPM_ADDR_CMPLO, cmps[i] & 32'hff);
            axw(`MWPM_ADDR_CMPHI, cmps[i] >> 8);
            axw(`MWPM_ADDR_MODCTL, i);
            axw(`MWPM_ADDR_CHMODE, 32'h4a);
            meas(8 + i, (1 << (8 + i)) - cmps[i]);
        end
        endt(2);
        // well inside the slack before the next wrap
        axw(`MWPM_ADDR_MODCTL, 32'h83);
        axw(`MWPM_ADDR_CMPLO, 32'h55);
        rc(`MWPM_ADDR_CMPLO, 32'h55);
        axw(`MWPM_ADDR_MODCTL, 32'h03);
        rc(`MWPM_ADDR_CMPLO, 32'hff);
        rc(`MWPM_ADDR_CMPHI, 32'h07);
        rc(`MWPM_ADDR_STATUS, 32'h3);
        chk({31'h0, irq}, 32'h1);
        axw(`MWPM_ADDR_CHMODE, 32'h42);
        axw(`MWPM_ADDR_STATUS, 32'h2);
        cnt(2100, c);
        rc(`MWPM_ADDR_STATUS, 32'h1);
        axw(`MWPM_ADDR_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        axw(`MWPM_ADDR_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        endt(3);
        axw(`MWPM_ADDR_CHMODE, 32'h4a);
        axw(`MWPM_ADDR_CMPLO, 32'h00);
        rc(`MWPM_ADDR_CHMODE, 32'h0a);
        cnt(2048, c);
        chk(c, 32'h0);
        axw(`MWPM_ADDR_CMPHI, 32'h04);
        rc(`MWPM_ADDR_CHMODE, 32'h4a);
        endt(4);
        axw(`MWPM_ADDR_MODCTL, 32'h00);
        cnt(2048, c);
        chk(c, 32'h0);
        axw(`MWPM_ADDR_MODCTL, 32'h03);
        axw(`MWPM_ADDR_CHMODE, 32'h48);
        cnt(2048, c);
        chk(c, 32'h0);
        endt(5);
        results();
    end
endmodule : mwpm_channel_bench
